/* File: hdl/ees_pkg.sv */
// Summary of operation
// - sda falling while scl high starts transfer
// - sda rising while scl high stops transfer
// - one bit per clock, data changes scl low
// - read data changes after scl falling edge
// - release after eight bits, receiver acks
// - ack matching address and every write byte
// - slave only, never drives clock or conditions
// - read: sample master ack, then next byte
// - no master ack: release, await stop
// - upper four address bits must match type
// - skip two bits, next is high address on writes, ignored on reads
// - last address bit: one reads, zero writes
// - memory 512 bytes, nine address bits
// - byte write commits after master stop
// - no response during internal write cycle
// - page write takes up to sixteen bytes
// - page write increments only low bits
// - over sixteen bytes wraps within page
// - starts ignored while write cycle runs
// - counter holds last address plus one
// - sequential read increments all bits, wraps
package ees_pkg;
  localparam int unsigned MEM_DEPTH = 512;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned PAGE_W = 4;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_DEPTH = 2;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h6;
  localparam logic RW_READ = 1'b1;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned T_WR_MS = 10;
  localparam int unsigned WR_CYCLES = T_WR_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_WAIT} ees_state_t;
  typedef enum logic [1:0] {PH_SLAVE, PH_WORD, PH_DATA} ees_phase_t;
  typedef enum logic [1:0] {WR_IDLE, WR_COPY, WR_BUSY} ees_wr_t;
endpackage

/* File: hdl/ees_if.sv */
`timescale 1ns/1ps
interface ees_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl, sda, scl_rise, scl_fall, start, stop);
  modport dst (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

interface ees_stream_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport fill (input data, valid, output ready);
  modport drain (output data, valid, input ready);
endinterface

/* File: hdl/ees_line_sync.sv */
`timescale 1ns/1ps
module ees_line_sync (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  // conditioned line events
  ees_line_if.src line
);
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce_i) begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign line.scl = scl_s;
  assign line.sda = sda_s;
  assign line.scl_rise = scl_s & ~scl_d;
  assign line.scl_fall = ~scl_s & scl_d;
  assign line.start = scl_s & scl_d & sda_d & ~sda_s;
  assign line.stop = scl_s & scl_d & ~sda_d & sda_s;
endmodule

/* File: hdl/ees_fifo2.sv */
`timescale 1ns/1ps
module ees_fifo2 (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // streams
  ees_stream_if.fill wr,
  ees_stream_if.drain rd
);
  import ees_pkg::*;
  logic [7:0] slot [0:FIFO_DEPTH-1];
  logic wp, rp;
  logic [1:0] cnt;
  wire push = wr.valid & wr.ready;
  wire pop = rd.valid & rd.ready;

  assign wr.ready = (cnt != 2'(FIFO_DEPTH));
  assign rd.valid = (cnt != 2'h0);
  assign rd.data = slot[rp];

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      slot[wp] <= wr.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end else if (ce_i) begin
      wp <= wp ^ push;
      rp <= rp ^ pop;
      cnt <= cnt + 2'(push) - 2'(pop);
    end
  end
endmodule

/* File: hdl/ees_eeprom_slave.sv */
`timescale 1ns/1ps
module ees_eeprom_slave #(
  parameter int unsigned WR_CYCLES = ees_pkg::WR_CYCLES,
  // device type code, value is arbitrary
  parameter logic [3:0] DEV_TYPE_CODE = ees_pkg::DEV_TYPE_DEFAULT
) (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // status
  output logic busy_o
);
  import ees_pkg::*;
  localparam int BUSY_W = $clog2(WR_CYCLES + 1);

  ees_line_if line ();
  ees_stream_if rx_q ();
  ees_stream_if pg_q ();

  ees_line_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .line(line.src)
  );

  ees_fifo2 u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr(rx_q.fill),
    .rd(pg_q.drain)
  );

  logic [7:0] mem [0:MEM_DEPTH-1];
  logic [7:0] page_buf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] page_vld;
  logic [ADDR_W-1:0] addr;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic rx_done, mack, rw_read, sda_oe_n, sda_level, wr_busy;
  logic push_vld;
  logic [7:0] push_data;
  ees_state_t st;
  ees_phase_t phase;
  ees_wr_t wr_st;
  logic [PAGE_W-1:0] cm_idx;
  logic [BUSY_W-1:0] busy_cnt;

  function automatic logic [ADDR_W-1:0] ees_next_addr(input logic [ADDR_W-1:0] a);
    ees_next_addr = a + 9'h001;
  endfunction

  // event decode
  wire fall = line.scl_fall;
  wire rise = line.scl_rise;
  wire bus_start = line.start & ~wr_busy;
  wire bus_stop = line.stop & ~wr_busy;
  wire take_byte = (st == ST_RX) & fall & rx_done;
  wire slave_ok = (shift[7:4] == DEV_TYPE_CODE);
  wire slave_is_read = (shift[0] == RW_READ);
  wire ack_now = (phase == PH_SLAVE) ? slave_ok : ((phase == PH_WORD) | ~push_vld);
  wire slave_take_w = take_byte & (phase == PH_SLAVE) & slave_ok & ~slave_is_read;
  wire word_take = take_byte & (phase == PH_WORD);
  wire tx_load = (st == ST_ACK) & fall & (phase == PH_SLAVE) & rw_read
    | (st == ST_MACK) & fall & mack;
  wire [7:0] mem_rd = mem[addr];
  wire drain = pg_q.valid & pg_q.ready;
  wire copy_step = (wr_st == WR_COPY) & ~push_vld & ~pg_q.valid;
  wire has_data = (page_vld != 16'h0000) | push_vld | pg_q.valid;
  wire commit_go = bus_stop & (st != ST_IDLE) & (phase == PH_DATA) & has_data;
  wire [ADDR_W-1:0] copy_addr = {addr[ADDR_W-1:PAGE_W], cm_idx};
  ees_phase_t next_phase;
  assign next_phase = (phase == PH_SLAVE) ? PH_WORD : PH_DATA;

  assign rx_q.valid = push_vld;
  assign rx_q.data = push_data;
  assign pg_q.ready = (wr_st != WR_BUSY);

  // bus protocol engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_IDLE;
      phase <= PH_SLAVE;
      rw_read <= 1'b0;
      bit_cnt <= 3'h0;
      rx_done <= 1'b0;
      mack <= 1'b0;
      shift <= 8'h00;
      sda_oe_n <= 1'b1;
      push_vld <= 1'b0;
      push_data <= 8'h00;
    end else if (ce_i) begin
      if (push_vld && rx_q.ready) begin
        push_vld <= 1'b0;
      end
      if (bus_start) begin
        st <= ST_RX;
        phase <= PH_SLAVE;
        bit_cnt <= 3'h0;
        rx_done <= 1'b0;
        mack <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (bus_stop) begin
        st <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        unique case (st)
          ST_IDLE, ST_WAIT: begin
          end
          ST_RX: begin
            if (rise) begin
              shift <= {shift[6:0], line.sda};
              bit_cnt <= bit_cnt + 3'h1;
              rx_done <= (bit_cnt == 3'h7);
            end else if (take_byte) begin
              rx_done <= 1'b0;
              bit_cnt <= 3'h0;
              if (phase == PH_SLAVE) begin
                rw_read <= slave_is_read;
              end
              if (ack_now) begin
                st <= ST_ACK;
                sda_oe_n <= 1'b0;
              end else begin
                st <= ST_WAIT;
              end
              if (phase == PH_DATA && ack_now) begin
                push_vld <= 1'b1;
                push_data <= shift;
              end
            end
          end
          ST_ACK: begin
            if (tx_load) begin
              st <= ST_TX;
              shift <= mem_rd;
              sda_oe_n <= mem_rd[7];
            end else if (fall) begin
              st <= ST_RX;
              phase <= next_phase;
              sda_oe_n <= 1'b1;
            end
          end
          ST_TX: begin
            if (fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                st <= ST_MACK;
                sda_oe_n <= 1'b1;
              end else begin
                sda_oe_n <= shift[6];
                shift <= {shift[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (rise) begin
              if (!line.sda) begin
                mack <= 1'b1;
              end else begin
                st <= ST_WAIT;
              end
            end else if (tx_load) begin
              mack <= 1'b0;
              bit_cnt <= 3'h0;
              st <= ST_TX;
              shift <= mem_rd;
              sda_oe_n <= mem_rd[7];
            end
          end
        endcase
      end
    end
  end

  // address counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr <= ADDR_RESET;
    end else if (ce_i) begin
      if (tx_load) begin
        addr <= ees_next_addr(addr);
      end else if (word_take) begin
        addr[7:0] <= shift;
      end else if (slave_take_w) begin
        addr[8] <= shift[1];
      end else if (drain) begin
        addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 4'h1;
      end
    end
  end

  // page buffer: later bytes overwrite earlier slots after a wrap
  always_ff @(posedge clk_i) begin
    if (ce_i && drain) begin
      page_buf[addr[PAGE_W-1:0]] <= pg_q.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_vld <= 16'h0000;
    end else if (ce_i) begin
      if (bus_start || wr_st == WR_BUSY) begin
        page_vld <= 16'h0000;
      end else if (drain) begin
        page_vld[addr[PAGE_W-1:0]] <= 1'b1;
      end
    end
  end

  // internal write cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_st <= WR_IDLE;
      cm_idx <= 4'h0;
      busy_cnt <= '0;
      wr_busy <= 1'b0;
    end else if (ce_i) begin
      unique case (wr_st)
        WR_IDLE: begin
          if (commit_go) begin
            wr_st <= WR_COPY;
            wr_busy <= 1'b1;
            cm_idx <= 4'h0;
          end
        end
        WR_COPY: begin
          if (copy_step) begin
            cm_idx <= cm_idx + 4'h1;
            if (cm_idx == 4'hF) begin
              wr_st <= WR_BUSY;
              busy_cnt <= BUSY_W'(WR_CYCLES - 1);
            end
          end
        end
        WR_BUSY: begin
          if (busy_cnt == '0) begin
            wr_st <= WR_IDLE;
            wr_busy <= 1'b0;
          end else begin
            busy_cnt <= busy_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && copy_step && page_vld[cm_idx]) begin
      mem[copy_addr] <= page_buf[cm_idx];
    end
  end

  // open-drain pin: only ever pulls low, never drives clock or conditions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_level <= 1'b0;
    end else if (ce_i) begin
      sda_level <= 1'b0;
    end
  end

  assign sda_o = sda_level;
  assign sda_oe_n_o = sda_oe_n;
  assign busy_o = wr_busy;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_byte_taken;
    ce_i && take_byte && ack_now;
  endsequence

  sequence s_ack_slot;
    (st == ST_ACK && !sda_oe_n) [*1] ##1 1;
  endsequence

  chk_start_begins: assert property (ce_i && bus_start |=> st == ST_RX)
    else $error("start did not begin a transfer");
  chk_stop_ends: assert property (ce_i && bus_stop |=> st == ST_IDLE && sda_oe_n)
    else $error("stop did not end the transfer");
  chk_drive_edge: assert property ($changed(sda_oe_n) |-> $past(fall || line.start || line.stop))
    else $error("data line changed away from clock low");
  chk_ack_drive: assert property (s_byte_taken |=> s_ack_slot)
    else $error("acknowledge not driven after accepted byte");
  chk_type_mismatch: assert property (ce_i && take_byte && phase == PH_SLAVE && !slave_ok
    |=> st == ST_WAIT && sda_oe_n)
    else $error("mismatched device type was acknowledged");
  chk_busy_silent: assert property (wr_busy |-> sda_oe_n && st != ST_RX)
    else $error("device responded during write cycle");
  chk_page_wrap: assert property (ce_i && drain && !tx_load && !word_take && !slave_take_w
    |=> addr[8:4] == $past(addr[8:4]) && addr[3:0] == $past(addr[3:0]) + 4'h1)
    else $error("page write address left its page");
  chk_seq_incr: assert property (ce_i && tx_load |=> addr == $past(addr) + 9'h001)
    else $error("read counter did not advance");
  chk_nack_release: assert property (ce_i && !bus_start && !bus_stop && st == ST_MACK && rise
    && line.sda |=> st == ST_WAIT ##1 sda_oe_n)
    else $error("missing master ack did not release line");
  chk_commit_busy: assert property (ce_i && wr_st == WR_IDLE && commit_go
    |=> wr_busy && wr_st == WR_COPY)
    else $error("stop after write did not start the write cycle");

  // a start seen while the write cycle runs must leave the engine idle
  chk_poll_ignored: assert property (ce_i && wr_busy && line.start |=> st == ST_IDLE)
    else $error("start accepted during write cycle");

  // the busy count ends the write cycle and frees the bus
  chk_cycle_end: assert property (ce_i && wr_st == WR_BUSY && busy_cnt == '0
    |=> !wr_busy && wr_st == WR_IDLE)
    else $error("write cycle did not end after its count");
endmodule

/* File: sim/ees_master.sv */
`timescale 1ns/1ps
module ees_master (
  // clock
  input wire logic clk_i,
  // bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_n_o,
  // observed results
  output logic res_v_o,
  output logic [7:0] res_d_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
    res_v_o = 1'b0;
    res_d_o = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic post(input logic [7:0] d);
    res_d_o <= d;
    res_v_o <= 1'b1;
    tick(1);
    res_v_o <= 1'b0;
  endtask

  // one scl pulse: data set mid-low, sampled mid-high
  task automatic bit_x(input logic b, output logic s);
    scl_o <= 1'b0;
    tick(2);
    sda_oe_n_o <= b;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    s = sda_i;
    tick(2);
  endtask

  // also serves as repeated start; sda is high while scl is high first
  task automatic start_c();
    scl_o <= 1'b0;
    tick(2);
    sda_oe_n_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(3);
    sda_oe_n_o <= 1'b0;
    tick(4);
  endtask

  task automatic stop_c();
    scl_o <= 1'b0;
    tick(2);
    sda_oe_n_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(3);
    sda_oe_n_o <= 1'b1;
    tick(6);
  endtask

  task automatic wbyte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], s);
    end
    bit_x(1'b1, s);
    post({7'h00, ~s});
  endtask

  task automatic rbyte(input logic ack);
    logic s;
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(~ack, s);
    post(d);
  endtask
endmodule

/* File: sim/ees_eeprom_slave_tb.sv */
`timescale 1ns/1ps
module ees_eeprom_slave_tb;
  import ees_pkg::*;
  localparam int unsigned WR_N = 400;
  localparam logic [3:0] DT = DEV_TYPE_DEFAULT;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic scl;
  logic m_oe_n;
  logic d_sda;
  logic d_oe_n;
  logic busy;
  logic res_v;
  logic [7:0] res_d;
  wire logic sda;
  logic [7:0] exp_q[$];
  logic [7:0] img [MEM_DEPTH];
  logic [31:0] seed = 32'h0000_372f;
  int error_cnt = 0;
  int total_checks = 0;

  // open drain with pull-up: low if either party pulls
  assign sda = (d_oe_n | d_sda) & m_oe_n;

  always #20 clk_i = ~clk_i;

  ees_eeprom_slave #(.WR_CYCLES(WR_N), .DEV_TYPE_CODE(DT)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .scl_i(scl), .sda_i(sda),
    .sda_o(d_sda), .sda_oe_n_o(d_oe_n), .busy_o(busy));

  ees_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n),
    .res_v_o(res_v), .res_d_o(res_d));

  function logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // slave byte with random don't-care bits
  function logic [7:0] sb(input logic [3:0] t, input logic a8, input logic rw);
    logic [7:0] r;
    r = rnd();
    return {t, r[1:0], a8, rw};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    if (res_v === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("CHECK FAILED at %0t: unexpected result", $time);
      end else begin
        check(res_d, exp_q.pop_front());
      end
    end
  end

  task automatic wr(input logic [7:0] d, input logic ack);
    exp_q.push_back({7'h00, ack});
    m.wbyte(d);
  endtask

  task automatic rd(input logic [8:0] a, input logic mack);
    exp_q.push_back(img[a]);
    m.rbyte(mack);
  endtask

  task automatic commit();
    for (int k = 0; k < 100 && busy !== 1'b1; k++) @(posedge clk_i);
    check({7'h00, busy}, 8'h01);
    m.start_c();
    wr(sb(DT, 1'b0, 1'b0), 1'b0);
    m.stop_c();
    for (int k = 0; k < WR_N + 200 && busy !== 1'b0; k++) @(posedge clk_i);
    check({7'h00, busy}, 8'h00);
    m.start_c();
    wr(sb(DT, 1'b0, 1'b0), 1'b1);
    m.stop_c();
  endtask

  task automatic rand_read(input logic [8:0] a, input int n);
    m.start_c();
    wr(sb(DT, a[8], 1'b0), 1'b1);
    wr(a[7:0], 1'b1);
    m.start_c();
    wr(sb(DT, ~a[8], 1'b1), 1'b1);
    for (int i = 0; i < n; i++) begin
      rd(9'(a + i), i < n - 1);
    end
    check({7'h00, d_oe_n}, 8'h01);
    m.stop_c();
  endtask

  initial begin
    logic [7:0] d;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({7'h00, d_oe_n}, 8'h01);
    check({7'h00, busy}, 8'h00);
    // frozen clock enable keeps the idle state
    ce_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check({7'h00, d_oe_n}, 8'h01);
    // foreign type code is not acknowledged
    m.start_c();
    wr(sb(~DT, 1'b0, 1'b0), 1'b0);
    m.stop_c();
    // byte write to the top location
    d = rnd();
    m.start_c();
    wr(sb(DT, 1'b1, 1'b0), 1'b1);
    wr(8'hff, 1'b1);
    wr(d, 1'b1);
    img[9'h1ff] = d;
    m.stop_c();
    commit();
    // eighteen bytes from offset e wrap within page zero
    m.start_c();
    wr(sb(DT, 1'b0, 1'b0), 1'b1);
    wr(8'h0e, 1'b1);
    for (int i = 0; i < 18; i++) begin
      d = rnd();
      wr(d, 1'b1);
      img[{5'h00, 4'(4'he + i)}] = d;
    end
    m.stop_c();
    commit();
    // write cut short by a repeated start leaves memory and busy alone
    m.start_c();
    wr(sb(DT, 1'b0, 1'b0), 1'b1);
    wr(8'h05, 1'b1);
    wr(~img[5], 1'b1);
    rand_read(9'h005, 1);
    repeat (40) @(posedge clk_i);
    check({7'h00, busy}, 8'h00);
    // sequential read across the top of memory, then current read
    rand_read(9'h1ff, 16);
    m.start_c();
    wr(sb(DT, 1'b1, 1'b1), 1'b1);
    rd(9'h00f, 1'b0);
    m.stop_c();
    repeat (20) @(posedge clk_i);
    check(8'(exp_q.size()), 8'h00);
    summarize();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
